// file: core/ccr_pkg.sv
// Purpose: Constants and carriers for the codec control register bank
// Assumes: APB slave with 32-bit data, one word per register
// Notes: Offsets are register indices; byte address is four times the index
package ccr_pkg;
  localparam int CCR_DW = 10;
  localparam logic [3:0] CCR_IDX_BB = 4'h6;
  localparam logic [3:0] CCR_IDX_V1 = 4'h8;
  localparam logic [3:0] CCR_IDX_V2 = 4'hB;
  localparam logic [9:0] CCR_RST_BB = 10'h000;
  localparam logic [9:0] CCR_RST_V1 = 10'h000;
  localparam logic [9:0] CCR_RST_V2 = 10'h000;
  localparam logic [9:0] CCR_V2_MASK = 10'h007;
  // Baseband control fields
  localparam int BB_CAL = 9;
  localparam int BB_LEV_HI = 8;
  localparam int BB_LEV_LO = 6;
  localparam int BB_MULTISLOT_SELECT = 5;
  localparam int BB_MOD = 4;
  localparam int BB_LOOP = 3;
  localparam int BB_CM_HI = 2;
  // Voice control one fields
  localparam int V1_BYP = 9;
  localparam int V1_AUXG = 8;
  localparam int V1_SYNC = 7;
  localparam int V1_CLK = 6;
  localparam int V1_LOOP = 5;
  localparam int V1_BIAS = 4;
  localparam int V1_ULSEL = 3;
  localparam int V1_BUZ = 2;
  localparam int V1_EAR = 1;
  localparam int V1_AUX = 0;
  // Voice control two fields
  localparam int V2_HSMIC = 2;
  localparam int V2_HSO = 1;
  localparam int V2_HSBIAS = 0;

  // Output level codes, binary codes for six levels
  typedef enum logic [2:0] {
    LEV_2X = 3'b000, LEV_16 = 3'b001, LEV_22 = 3'b010, LEV_8 = 3'b011,
    LEV_18 = 3'b100, LEV_20 = 3'b101
  } ccr_level_type;

  typedef enum logic [2:0] {
    CM_HALF = 3'b000, CM_135 = 3'b001, CM_145 = 3'b010, CM_118 = 3'b011,
    CM_125 = 3'b100
  } ccr_cm_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ccr_apb_req_type;

  typedef struct packed {
    logic cal_external;
    ccr_level_type level;
    logic use_buf0;
    logic use_buf1;
    logic gmsk_mode;
    logic bb_loop;
    ccr_cm_type common_mode;
  } ccr_bb_ctl_type;

  typedef struct packed {
    logic filter_bypass;
    logic aux_gain_high;
    logic clock_continuous;
    logic voice_loop;
    logic bias_high;
    logic main_mic_sel;
    logic ear_on;
    logic aux_out_on;
    logic headset_mic_sel;
    logic headset_on;
    logic headset_bias_on;
    logic main_bias_on;
    logic voice_digital_reset;
  } ccr_voice_ctl_type;
endpackage : ccr_pkg

// file: core/ccr_regs.sv
// Purpose: Codec control register bank on APB with decoded control outputs
// Assumes: Single clock CLK, asynchronous active-low NRST, power-on bits from outside
// Notes: Always ready, no wait states; unmapped addresses read zero, error high
//
// Notes on behaviour
// R01 - Baseband bit 9 picks automatic calibration at 0, external at 1.
// R02 - Bits 8..6 pick output level; codes 10x and 11x ignore their low bit.
// R03 - Multislot bit 5: 0 uses buffer 1 only, 1 alternates buffers 0 and 1.
// R04 - Modulation bit 4 cleared selects GMSK uplink mode.
// R05 - Loopback bit 3 routes I/Q uplink back to I/Q downlink.
// R06 - Bits 2..0 pick uplink common mode; any 1xx gives one value.
// R07 - Voice bit 9 bypasses filter, gain stage and volume when set.
// R08 - Voice bit 8 picks low or high aux input amplifier gain.
// R09 - With sync enable bit 7 set, sync pin resets modulator, port, filter.
// R10 - A sync pin reset clears the sync enable bit by itself.
// R11 - Voice bit 6 picks burst (0) or continuous (1) serial clock.
// R12 - Voice loopback bit 5 feeds output samples into audio converter input.
// R13 - Software sets safe gains and mute sidetone before enabling voice loopback.
// R14 - Voice bit 4 picks lower or higher microphone bias.
// R15 - Bit 3: 0 selects aux input; 1 selects main mic only with uplink power.
// R16 - Buzzer power-down bit 2 forces aux out and earpiece stages off.
// R17 - Earpiece enable bit 1 acts only with downlink power on.
// R18 - Aux out enable bit 0 acts only with downlink power on.
// R19 - Second register bit 2 picks headset mic pin at 1, aux pin at 0.
// R20 - Headset enable bit 1 acts only with downlink power on.
// R21 - Bit 0 activates headset bias at 1, main mic bias at 0.
// R22 - Second register bits 9..3 read zero and ignore writes.
// R23 - Downlink and uplink power-on bits arrive as inputs.
`timescale 1ns/1ps
module ccr_regs (
  input wire logic CLK,
  input wire logic NRST,
  input wire ccr_pkg::ccr_apb_req_type APB_REQ,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic DOWNLINK_POWER_ON,
  input wire logic UPLINK_POWER_ON,
  input wire logic VOICE_SYNC_RESET_PIN,
  input wire logic BURST_DONE,
  output ccr_pkg::ccr_bb_ctl_type BB_CTL,
  output ccr_pkg::ccr_voice_ctl_type VOICE_CTL
);
  import ccr_pkg::*;

  // ----------------------------------------------------------------
  // Register storage and bus decode
  // ----------------------------------------------------------------
  logic [9:0] bb_r;
  logic [9:0] v1_r;
  logic [9:0] v2_r;
  logic buf_sel_r;
  logic [2:0] sync_pin_r;
  logic sync_fire;
  logic sel_bb;
  logic sel_v1;
  logic sel_v2;
  logic mapped;
  logic wr_en;
  logic rd_en;
  logic [31:0] rd_nxt;

  function automatic logic hit(input logic [11:0] addr, input logic [3:0] idx);
    hit = (addr[11:6] == 6'h00) && (addr[5:2] == idx) && (addr[1:0] == 2'b00);
  endfunction : hit

  assign sel_bb = hit(APB_REQ.paddr, CCR_IDX_BB);
  assign sel_v1 = hit(APB_REQ.paddr, CCR_IDX_V1);
  assign sel_v2 = hit(APB_REQ.paddr, CCR_IDX_V2);
  assign mapped = sel_bb | sel_v1 | sel_v2;
  assign wr_en = APB_REQ.psel & APB_REQ.penable & APB_REQ.pwrite & mapped;
  assign rd_en = APB_REQ.psel & ~APB_REQ.penable & ~APB_REQ.pwrite;

  // ----------------------------------------------------------------
  // Sync pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      sync_pin_r <= 3'b000;
    end else begin
      sync_pin_r <= {sync_pin_r[1:0], VOICE_SYNC_RESET_PIN};
    end
  end

  // Pin counts once second and third stages agree high
  assign sync_fire = sync_pin_r[1] & sync_pin_r[2] & v1_r[V1_SYNC]; // R09

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      bb_r <= CCR_RST_BB;
    end else if (wr_en && sel_bb) begin
      bb_r <= APB_REQ.pwdata[9:0];
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      v1_r <= CCR_RST_V1;
    end else begin
      if (wr_en && sel_v1) begin
        v1_r <= APB_REQ.pwdata[9:0];
      end
      // Hardware clear beats a same-cycle write that would keep it set
      if (sync_fire) begin
        v1_r[V1_SYNC] <= 1'b0; // R10
      end
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      v2_r <= CCR_RST_V2;
    end else if (wr_en && sel_v2) begin
      v2_r <= APB_REQ.pwdata[9:0] & CCR_V2_MASK; // R22
    end
  end

  // ----------------------------------------------------------------
  // Burst buffer alternation
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      buf_sel_r <= 1'b1;
    end else if (!bb_r[BB_MULTISLOT_SELECT]) begin
      buf_sel_r <= 1'b1; // R03
    end else if (BURST_DONE) begin
      buf_sel_r <= ~buf_sel_r; // R03
    end
  end

  // ----------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (sel_bb) begin
      rd_nxt[9:0] = bb_r;
    end else if (sel_v1) begin
      rd_nxt[9:0] = v1_r;
    end else if (sel_v2) begin
      rd_nxt[9:0] = v2_r & CCR_V2_MASK; // R22
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      PRDATA <= 32'h0000_0000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      if (rd_en) begin
        PRDATA <= rd_nxt;
      end
      PREADY <= APB_REQ.psel & ~APB_REQ.penable;
      PSLVERR <= APB_REQ.psel & ~APB_REQ.penable & ~mapped;
    end
  end

  // ----------------------------------------------------------------
  // Decoded control outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      BB_CTL <= '0;
    end else begin
      BB_CTL.cal_external <= bb_r[BB_CAL]; // R01
      BB_CTL.level <= ccr_level_type'(bb_r[BB_LEV_HI] ?
        {2'b10, bb_r[BB_LEV_HI-1]} : bb_r[BB_LEV_HI:BB_LEV_LO]); // R02
      BB_CTL.use_buf0 <= bb_r[BB_MULTISLOT_SELECT] & ~buf_sel_r; // R03
      BB_CTL.use_buf1 <= ~bb_r[BB_MULTISLOT_SELECT] | buf_sel_r; // R03
      BB_CTL.gmsk_mode <= ~bb_r[BB_MOD]; // R04
      BB_CTL.bb_loop <= bb_r[BB_LOOP]; // R05
      BB_CTL.common_mode <= ccr_cm_type'(bb_r[BB_CM_HI] ? 3'b100 : bb_r[2:0]); // R06
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      VOICE_CTL <= '0;
    end else begin
      VOICE_CTL.filter_bypass <= v1_r[V1_BYP]; // R07
      VOICE_CTL.aux_gain_high <= v1_r[V1_AUXG]; // R08
      VOICE_CTL.voice_digital_reset <= sync_fire; // R09
      VOICE_CTL.clock_continuous <= v1_r[V1_CLK]; // R11
      VOICE_CTL.voice_loop <= v1_r[V1_LOOP]; // R12
      VOICE_CTL.bias_high <= v1_r[V1_BIAS]; // R14
      VOICE_CTL.main_mic_sel <= v1_r[V1_ULSEL] & UPLINK_POWER_ON; // R15 R23
      VOICE_CTL.ear_on <= v1_r[V1_EAR] & DOWNLINK_POWER_ON & ~v1_r[V1_BUZ]; // R16 R17
      VOICE_CTL.aux_out_on <= v1_r[V1_AUX] & DOWNLINK_POWER_ON & ~v1_r[V1_BUZ]; // R16 R18
      VOICE_CTL.headset_mic_sel <= v2_r[V2_HSMIC]; // R19
      VOICE_CTL.headset_on <= v2_r[V2_HSO] & DOWNLINK_POWER_ON; // R20
      VOICE_CTL.headset_bias_on <= v2_r[V2_HSBIAS]; // R21
      VOICE_CTL.main_bias_on <= ~v2_r[V2_HSBIAS]; // R21
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_cal_follow: assert property (@(posedge CLK) disable iff (!NRST) // R01
    ##1 BB_CTL.cal_external == $past(bb_r[BB_CAL])) else $error("cal select wrong");
  a_level_map: assert property (@(posedge CLK) disable iff (!NRST) // R02
    $past(bb_r[8:7]) == 2'b11 |-> BB_CTL.level == LEV_20) else $error("level map wrong");
  a_single_slot: assert property (@(posedge CLK) disable iff (!NRST) // R03
    (NRST && !bb_r[BB_MULTISLOT_SELECT]) [*2] |-> BB_CTL.use_buf1 && !BB_CTL.use_buf0)
    else $error("single slot uses buffer 0");
  a_buf_swap: assert property (@(posedge CLK) disable iff (!NRST) // R03
    bb_r[BB_MULTISLOT_SELECT] && BURST_DONE |=> buf_sel_r != $past(buf_sel_r)) else $error("no swap");
  a_gmsk_mode: assert property (@(posedge CLK) disable iff (!NRST) // R04
    $past(NRST) |-> BB_CTL.gmsk_mode == !$past(bb_r[BB_MOD])) else $error("gmsk wrong");
  a_cm_high: assert property (@(posedge CLK) disable iff (!NRST) // R06
    $past(bb_r[2]) |-> BB_CTL.common_mode == CM_125) else $error("common mode wrong");
  a_sync_clear: assert property (@(posedge CLK) disable iff (!NRST) // R10
    sync_fire |=> !v1_r[V1_SYNC] ##1 VOICE_CTL.voice_digital_reset == 1'b0)
    else $error("sync enable not cleared");
  a_sync_reset: assert property (@(posedge CLK) disable iff (!NRST) // R09
    sync_fire |=> VOICE_CTL.voice_digital_reset) else $error("no digital reset");
  a_buz_off: assert property (@(posedge CLK) disable iff (!NRST) // R16
    $past(v1_r[V1_BUZ]) |-> !VOICE_CTL.ear_on && !VOICE_CTL.aux_out_on)
    else $error("buzzer power down ignored");
  a_dl_gate: assert property (@(posedge CLK) disable iff (!NRST) // R20
    !$past(DOWNLINK_POWER_ON) |-> !VOICE_CTL.headset_on) else $error("headset ungated");
  a_mic_gate: assert property (@(posedge CLK) disable iff (!NRST) // R15
    !$past(UPLINK_POWER_ON) |-> !VOICE_CTL.main_mic_sel) else $error("mic ungated");
  a_rsvd_zero: assert property (@(posedge CLK) disable iff (!NRST) // R22
    v2_r[9:3] == 7'h00) else $error("reserved bits set");

  a_level_low: assert property (@(posedge CLK) disable iff (!NRST) // R02
    $past(NRST) && !$past(bb_r[BB_LEV_HI])
    |-> BB_CTL.level == ccr_level_type'($past(bb_r[BB_LEV_HI:BB_LEV_LO])))
    else $error("low level code wrong");

  a_level_mid: assert property (@(posedge CLK) disable iff (!NRST) // R02
    $past(bb_r[8:7]) == 2'b10
    |-> BB_CTL.level == LEV_18)
    else $error("mid level code wrong");

  a_bb_loop: assert property (@(posedge CLK) disable iff (!NRST) // R05
    $past(NRST)
    |-> BB_CTL.bb_loop == $past(bb_r[BB_LOOP]))
    else $error("baseband loop wrong");

  a_cm_low: assert property (@(posedge CLK) disable iff (!NRST) // R06
    $past(NRST) && !$past(bb_r[BB_CM_HI])
    |-> BB_CTL.common_mode == ccr_cm_type'($past(bb_r[BB_CM_HI:0])))
    else $error("low common mode wrong");

  a_filter_byp: assert property (@(posedge CLK) disable iff (!NRST) // R07
    $past(NRST)
    |-> VOICE_CTL.filter_bypass == $past(v1_r[V1_BYP]))
    else $error("filter bypass wrong");

  a_aux_gain: assert property (@(posedge CLK) disable iff (!NRST) // R08
    $past(NRST)
    |-> VOICE_CTL.aux_gain_high == $past(v1_r[V1_AUXG]))
    else $error("aux gain wrong");

  a_sync_idle: assert property (@(posedge CLK) disable iff (!NRST) // R09
    !sync_fire
    |=> !VOICE_CTL.voice_digital_reset)
    else $error("spurious digital reset");

  a_clk_mode: assert property (@(posedge CLK) disable iff (!NRST) // R11
    $past(NRST)
    |-> VOICE_CTL.clock_continuous == $past(v1_r[V1_CLK]))
    else $error("clock mode wrong");

  a_voice_loop: assert property (@(posedge CLK) disable iff (!NRST) // R12
    $past(NRST)
    |-> VOICE_CTL.voice_loop == $past(v1_r[V1_LOOP]))
    else $error("voice loop wrong");

  a_bias_level: assert property (@(posedge CLK) disable iff (!NRST) // R14
    $past(NRST)
    |-> VOICE_CTL.bias_high == $past(v1_r[V1_BIAS]))
    else $error("bias level wrong");

  a_aux_sel: assert property (@(posedge CLK) disable iff (!NRST) // R15
    !$past(v1_r[V1_ULSEL])
    |-> !VOICE_CTL.main_mic_sel)
    else $error("main mic without select");

  a_mic_on: assert property (@(posedge CLK) disable iff (!NRST) // R15
    $past(v1_r[V1_ULSEL] && UPLINK_POWER_ON)
    |-> VOICE_CTL.main_mic_sel)
    else $error("main mic not selected");

  a_ear_gate: assert property (@(posedge CLK) disable iff (!NRST) // R17
    !$past(DOWNLINK_POWER_ON)
    |-> !VOICE_CTL.ear_on)
    else $error("earpiece ungated");

  a_ear_on: assert property (@(posedge CLK) disable iff (!NRST) // R17
    $past(v1_r[V1_EAR] && !v1_r[V1_BUZ] && DOWNLINK_POWER_ON)
    |-> VOICE_CTL.ear_on)
    else $error("earpiece not on");

  a_aux_gate: assert property (@(posedge CLK) disable iff (!NRST) // R18
    !$past(DOWNLINK_POWER_ON)
    |-> !VOICE_CTL.aux_out_on)
    else $error("aux out ungated");

  a_hs_mic: assert property (@(posedge CLK) disable iff (!NRST) // R19
    $past(NRST)
    |-> VOICE_CTL.headset_mic_sel == $past(v2_r[V2_HSMIC]))
    else $error("headset mic select wrong");

  a_hs_on: assert property (@(posedge CLK) disable iff (!NRST) // R20
    $past(v2_r[V2_HSO] && DOWNLINK_POWER_ON)
    |-> VOICE_CTL.headset_on)
    else $error("headset not on");

  a_hs_bias: assert property (@(posedge CLK) disable iff (!NRST) // R21
    $past(NRST) |-> VOICE_CTL.headset_bias_on == $past(v2_r[V2_HSBIAS])
    && VOICE_CTL.main_bias_on == !$past(v2_r[V2_HSBIAS]))
    else $error("bias select wrong");

  a_rsvd_read: assert property (@(posedge CLK) disable iff (!NRST) // R22
    $past(APB_REQ.psel && !APB_REQ.penable && !APB_REQ.pwrite && sel_v2)
    |-> PRDATA[9:3] == 7'h00)
    else $error("reserved bits read set");

  // ----------------------------------------------------------------
  // Bus checks
  // ----------------------------------------------------------------
  a_ready_setup: assert property (@(posedge CLK) disable iff (!NRST)
    APB_REQ.psel && !APB_REQ.penable
    |=> PREADY)
    else $error("no ready after setup");

  a_err_ready: assert property (@(posedge CLK) disable iff (!NRST)
    PSLVERR
    |-> PREADY)
    else $error("error without ready");

  a_data_top: assert property (@(posedge CLK) disable iff (!NRST)
    PRDATA[31:10] == 22'h00_0000)
    else $error("read data upper bits set");
endmodule : ccr_regs

// file: verification/ccr_regs_tb.sv
// Purpose: Self-checking bench for the codec control register bank
// Assumes: Always-ready APB slave, byte address four times the register index
// Notes: Control outputs are sampled a few edges after each write
`timescale 1ns/1ps
module ccr_regs_tb;
  import ccr_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  ccr_apb_req_type req = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic dl_on = 1'b0;
  logic ul_on = 1'b0;
  logic sync_pin = 1'b0;
  logic burst_done = 1'b0;
  ccr_bb_ctl_type bb;
  ccr_voice_ctl_type vc;
  logic [31:0] rd;
  logic err;
  logic seen_rst;
  logic [31:0] w;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  localparam logic [11:0] A_BB = 12'h018;
  localparam logic [11:0] A_V1 = 12'h020;
  localparam logic [11:0] A_V2 = 12'h02C;

  ccr_regs uut (.CLK(clk), .NRST(nrst), .APB_REQ(req), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .DOWNLINK_POWER_ON(dl_on), .UPLINK_POWER_ON(ul_on),
    .VOICE_SYNC_RESET_PIN(sync_pin), .BURST_DONE(burst_done), .BB_CTL(bb), .VOICE_CTL(vc));

  always #20 clk = ~clk;

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  // ----------------------------------------
  // Bus and compare helpers
  // ----------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge clk);
    req.penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask : settle

  task automatic pulse_burst();
    @(posedge clk);
    burst_done <= 1'b1;
    @(posedge clk);
    burst_done <= 1'b0;
    settle();
  endtask : pulse_burst

  task automatic sync_pulse();
    seen_rst = 1'b0;
    @(posedge clk);
    sync_pin <= 1'b1;
    repeat (2) @(posedge clk);
    sync_pin <= 1'b0;
    repeat (10) begin
      @(posedge clk);
      if (vc.voice_digital_reset === 1'b1) seen_rst = 1'b1;
    end
  endtask : sync_pulse

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      end_of_test();
    end
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    settle();
    apb(1'b0, A_BB, 32'h0);
    check(rd, 32'h0);
    check({bb.use_buf1, bb.use_buf0, bb.gmsk_mode}, 32'h5);
    check(vc.main_bias_on, 32'h1);
    for (int i = 0; i < 8; i++) begin
      w = {22'h0, i[0], i[2:0], 1'b0, i[1], i[0], i[2:0]};
      apb(1'b1, A_BB, w);
      settle();
      check(bb.level, (i < 4) ? i : 4 + i[1]);
      check(bb.common_mode, (i < 4) ? i : 4);
      check({bb.cal_external, bb.bb_loop}, {i[0], i[0]});
      check(bb.gmsk_mode, !i[1]);
      apb(1'b0, A_BB, 32'h0);
      check(rd, w);
    end
    $display("baseband fields done");
    pulse_burst();
    check({bb.use_buf0, bb.use_buf1}, 32'h1);
    apb(1'b1, A_BB, 32'h0000_0020);
    settle();
    check({bb.use_buf0, bb.use_buf1}, 32'h1);
    pulse_burst();
    check({bb.use_buf0, bb.use_buf1}, 32'h2);
    pulse_burst();
    check({bb.use_buf0, bb.use_buf1}, 32'h1);
    $display("multislot done");
    for (int j = 0; j < 12; j++) begin
      w = (j < 4) ? 32'h0000_037B : (j < 8) ? 32'h0000_037F : 32'h0;
      @(posedge clk);
      dl_on <= j[0];
      ul_on <= j[1];
      apb(1'b1, A_V1, w);
      settle();
      check({vc.filter_bypass, vc.aux_gain_high, vc.clock_continuous}, {w[9:8], w[6]});
      check({vc.voice_loop, vc.bias_high}, w[5:4]);
      check(vc.main_mic_sel, w[3] & j[1]);
      check(vc.ear_on, w[1] & !w[2] & j[0]);
      check(vc.aux_out_on, w[0] & !w[2] & j[0]);
    end
    for (int k = 0; k < 4; k++) begin
      w = k[1] ? 32'h0000_03F8 : 32'h0000_03FF;
      @(posedge clk);
      dl_on <= k[0];
      apb(1'b1, A_V2, w);
      settle();
      apb(1'b0, A_V2, 32'h0);
      check(rd, w & 32'h0000_0007);
      check(vc.headset_mic_sel, w[2]);
      check(vc.headset_on, w[1] & k[0]);
      check({vc.headset_bias_on, vc.main_bias_on}, {w[0], !w[0]});
    end
    $display("voice fields done");
    apb(1'b1, A_V1, 32'h0000_0080);
    sync_pulse();
    check(seen_rst, 1'b1);
    apb(1'b0, A_V1, 32'h0);
    check(rd, 32'h0);
    sync_pulse();
    check(seen_rst, 1'b0);
    $display("sync reset done");
    apb(1'b1, 12'h01C, 32'h0000_03FF);
    check(err, 1'b1);
    apb(1'b0, 12'h01C, 32'h0);
    check(err, 1'b1);
    check(rd, 32'h0);
    $display("unmapped done");
    end_of_test();
  end
endmodule : ccr_regs_tb
